// file: ssf_pkg.sv
// Package with register map, field positions and timing constants for the status flag bank
// How it works
// R1 - Diagnostic error flag sets on a diagnosis error and stays on until cleared under R3.
// R2 - Self-diagnostic error flag sets on error and holds until acknowledged or cleared under R3.
// R3 - Falling motion error detect flag clears both latched error flags for non-stop errors.
// R4 - Battery low latch sets below 2.5 V and stays on after recovery.
// R5 - Live battery flags follow the low and warning comparators directly; the code updates them only at main pass.
// R6 - Battery warning latch sets below 2.7 V and stays on after recovery.
// R7 - Supply down flag sets on an interruption up to 20 ms; power cycle clears.
// R8 - Other supply module: interruption up to 10 ms sets the same flag.
// R9 - Each flag has a setter attribute; only user-settable flags accept writes.
// R10 - System flags update only at their listed update moment.
// R11 - All flags, supply down included, start off after reset.
`default_nettype none
package ssf_pkg;
  // Byte addresses of the registers
  localparam logic [11:0] ADDR_FLAGS = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_ATTR = 12'h008;
  // Bit positions in the flag word
  localparam int BIT_DIAG = 0;
  localparam int BIT_SELF = 1;
  localparam int BIT_BLOW_L = 2;
  localparam int BIT_BLOW = 3;
  localparam int BIT_SDOWN = 4;
  localparam int BIT_BWARN_L = 5;
  localparam int BIT_BWARN = 6;
  localparam int NUM_FLAGS = 7;
  // Control bits
  localparam int CTRL_ACK = 0;
  localparam int CTRL_SUPPLY_ALT = 1;
  // Setter attribute codes, two bits per flag
  localparam logic [1:0] SET_SYS = 2'h0;
  localparam logic [1:0] SET_USER = 2'h1;
  localparam logic [1:0] SET_BOTH = 2'h2;
  // Attribute per flag: all system-set
  localparam logic [13:0] ATTR_RESET = 14'h0000;
  localparam logic [6:0] FLAGS_RESET = 7'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Interruption windows
  localparam int CLK_HZ = 20000000;
  localparam int DOWN_LONG_MS = 20;
  localparam int DOWN_SHORT_MS = 10;
  localparam int DOWN_LONG_CYC = CLK_HZ / 1000 * DOWN_LONG_MS;
  localparam int DOWN_SHORT_CYC = CLK_HZ / 1000 * DOWN_SHORT_MS;
  // Group of condition inputs
  typedef struct packed {
    logic diag_err;
    logic self_diag_err;
    logic batt_below_low;
    logic batt_below_warn;
    logic supply_lost;
    logic motion_error_detect_flag;
    logic motion_stop_error;
  } ssf_cond_t;
  // Update moments
  typedef struct packed {
    logic main_pass;
    logic error_event;
    logic op_cycle;
  } ssf_tick_t;
endpackage : ssf_pkg
`default_nettype wire

// file: ssf_flag_bank.sv
// Status flag bank with APB register access
`default_nettype none
module ssf_flag_bank #(
  parameter int DOWN_LONG_CYCLES = ssf_pkg::DOWN_LONG_CYC,
  parameter int DOWN_SHORT_CYCLES = ssf_pkg::DOWN_SHORT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Conditions and update moments
  input wire ssf_pkg::ssf_cond_t cond,
  input wire ssf_pkg::ssf_tick_t tick,
  // Flag word
  output logic [6:0] flags
);
  logic [1:0] ctrl;
  logic [13:0] attr;
  logic motion_prev;
  logic [31:0] down_cnt;
  logic down_hit;
  logic ack_pulse;
  logic clear_latch;
  logic wr_en;
  logic [6:0] user_mask;
  logic [6:0] next_flags;
  logic [31:0] next_rdata;
  logic addr_ok;

  assign wr_en = psel && penable && pwrite;
  assign ack_pulse = wr_en && paddr == ssf_pkg::ADDR_CTRL && pwdata[ssf_pkg::CTRL_ACK];
  // R3 falling edge clear
  assign clear_latch = motion_prev && !cond.motion_error_detect_flag && !cond.motion_stop_error;

  // R9 user-writable mask from attributes
  genvar g;
  generate
    for (g = 0; g < ssf_pkg::NUM_FLAGS; g++) begin : g_mask
      assign user_mask[g] = attr[2*g +: 2] != ssf_pkg::SET_SYS;
    end
  endgenerate

  // Edge memory of motion error flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motion_prev <= 1'b0;
    end else begin
      motion_prev <= cond.motion_error_detect_flag;
    end
  end

  // R7 R8 interruption length counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_cnt <= 32'h0000_0000;
      down_hit <= 1'b0;
    end else if (cond.supply_lost) begin
      if (down_cnt != 32'hffff_ffff) begin
        down_cnt <= down_cnt + 32'h0000_0001;
      end
      down_hit <= 1'b0;
    end else begin
      down_hit <= down_cnt != 32'h0000_0000 && down_cnt <= (ctrl[ssf_pkg::CTRL_SUPPLY_ALT] ?
          32'(DOWN_SHORT_CYCLES) : 32'(DOWN_LONG_CYCLES));
      down_cnt <= 32'h0000_0000;
    end
  end

  // Next flag values
  always_comb begin
    next_flags = flags;
    // R1 diagnostic latch at error moment
    if (tick.error_event && cond.diag_err) begin
      next_flags[ssf_pkg::BIT_DIAG] = 1'b1;
    end else if (clear_latch) begin
      next_flags[ssf_pkg::BIT_DIAG] = 1'b0;
    end
    // R2 self-diagnostic latch with acknowledge
    if (tick.error_event && cond.self_diag_err) begin
      next_flags[ssf_pkg::BIT_SELF] = 1'b1;
    end else if (clear_latch || ack_pulse) begin
      next_flags[ssf_pkg::BIT_SELF] = 1'b0;
    end
    // R10 battery flags at main pass
    if (tick.main_pass) begin
      // R4 low latch
      if (cond.batt_below_low) begin
        next_flags[ssf_pkg::BIT_BLOW_L] = 1'b1;
      end
      // R6 warning latch
      if (cond.batt_below_warn) begin
        next_flags[ssf_pkg::BIT_BWARN_L] = 1'b1;
      end
      // R5 live flags
      next_flags[ssf_pkg::BIT_BLOW] = cond.batt_below_low;
      next_flags[ssf_pkg::BIT_BWARN] = cond.batt_below_warn;
    end
    // R7 supply down sticky
    if (down_hit) begin
      next_flags[ssf_pkg::BIT_SDOWN] = 1'b1;
    end
    // R9 user writes to writable flags
    if (wr_en && paddr == ssf_pkg::ADDR_FLAGS) begin
      next_flags = (next_flags & ~user_mask) | (pwdata[6:0] & user_mask);
    end
  end

  // R11 flags start off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= ssf_pkg::FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // Control and attribute registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ssf_pkg::CTRL_RESET;
      attr <= ssf_pkg::ATTR_RESET;
    end else if (wr_en && paddr == ssf_pkg::ADDR_CTRL) begin
      ctrl <= {pwdata[ssf_pkg::CTRL_SUPPLY_ALT], 1'b0};
    end else if (wr_en && paddr == ssf_pkg::ADDR_ATTR) begin
      attr <= pwdata[13:0];
    end
  end

  // Read decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      ssf_pkg::ADDR_FLAGS: next_rdata = {25'h0, flags};
      ssf_pkg::ADDR_CTRL: next_rdata = {30'h0, ctrl};
      ssf_pkg::ADDR_ATTR: next_rdata = {18'h0, attr};
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer, one cycle access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end
endmodule : ssf_flag_bank
`default_nettype wire

// file: ssf_flag_bank_sva.sv
// Checker for the status flag bank
`default_nettype none
module ssf_flag_bank_sva #(
  parameter int DOWN_LONG_CYCLES = 20,
  parameter int DOWN_SHORT_CYCLES = 10
) (
  // Clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flags
  input wire ssf_pkg::ssf_cond_t cond,
  input wire ssf_pkg::ssf_tick_t tick,
  input wire logic [6:0] flags
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Battery and error flag checks
  live_low_a: assert property (tick.main_pass |=> flags[3] == $past(cond.batt_below_low))
    else $error("live low wrong");
  live_warn_a: assert property (tick.main_pass |=> flags[6] == $past(cond.batt_below_warn))
    else $error("live warn wrong");
  low_set_a: assert property (tick.main_pass && cond.batt_below_low |=> flags[2])
    else $error("low latch not set");
  latch_hold_a: assert property ($past(!(psel && pwrite)) |->
    (flags & $past(flags) & 7'h34) == ($past(flags) & 7'h34)) else $error("latch lost");
  diag_set_a: assert property (tick.error_event && cond.diag_err |=> flags[0])
    else $error("diag not set");
  motion_clear_a: assert property ($fell(cond.motion_error_detect_flag) &&
    !cond.motion_stop_error && !tick.error_event && !psel |=> flags[1:0] == 2'h0)
    else $error("diag not cleared");
  // Bus answers
  ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready");
  unmapped_a: assert property (psel && !penable && paddr > 12'h008 |=> pslverr)
    else $error("no slave error");
  cover property (flags[4]);
  cover property (flags[1:0] == 2'h3);
  cover property (pready && pslverr);
endmodule : ssf_flag_bank_sva
bind ssf_flag_bank ssf_flag_bank_sva #(.DOWN_LONG_CYCLES(DOWN_LONG_CYCLES),
  .DOWN_SHORT_CYCLES(DOWN_SHORT_CYCLES)) u_sva (.*);
`default_nettype wire

// file: ssf_flag_bank_tb.sv
// Self-checking bench for the status flag bank
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module ssf_flag_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] flags;
  ssf_pkg::ssf_cond_t cond;
  ssf_pkg::ssf_tick_t tick;
  int num_errors, compares, cyc;
  ssf_flag_bank #(.DOWN_LONG_CYCLES(20), .DOWN_SHORT_CYCLES(10)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond),
    .tick(tick), .flags(flags));
  // Clock and hang guard
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) if (++cyc > 2000) begin
    num_errors++;
    end_sim();
  end
  task automatic go(input int k);
    repeat (k) @(posedge pclk);
  endtask : go
  task automatic rst();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    go(1);
  endtask : rst
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    go(1);
  endtask : apb
  task automatic pulse(input ssf_pkg::ssf_tick_t t);
    @(posedge pclk);
    tick <= t;
    @(posedge pclk);
    tick <= '0;
    go(1);
  endtask : pulse
  task automatic mot(input logic s);
    cond.motion_stop_error <= s;
    cond.motion_error_detect_flag <= 1'b1;
    go(1);
    cond.motion_error_detect_flag <= 1'b0;
    go(2);
  endtask : mot
  task automatic down(input int k);
    cond.supply_lost <= 1'b1;
    go(k);
    cond.supply_lost <= 1'b0;
    go(3);
  endtask : down
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cond, tick} = '0;
    rst();
    `CHK("reset", 7'h00, flags)
    cond.batt_below_low <= 1'b1;
    cond.batt_below_warn <= 1'b1;
    cond.diag_err <= 1'b1;
    cond.self_diag_err <= 1'b1;
    go(2);
    `CHK("no tick", 7'h00, flags)
    pulse(3'h4);
    `CHK("batt", 7'h6c, flags)
    pulse(3'h2);
    cond <= '0;
    pulse(3'h4);
    `CHK("latched", 7'h27, flags)
    mot(1'b1);
    `CHK("stop err", 2'h3, flags[1:0])
    mot(1'b0);
    `CHK("cleared", 2'h0, flags[1:0])
    cond.self_diag_err <= 1'b1;
    pulse(3'h2);
    cond.self_diag_err <= 1'b0;
    apb(1'b1, 12'h004, 32'h1);
    `CHK("ack", 1'b0, flags[1])
    apb(1'b1, 12'h000, 32'h1);
    `CHK("sys only", 1'b0, flags[0])
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    `CHK("user", 1'b1, flags[0])
    apb(1'b0, 12'h000, 32'h0);
    `CHK("read flags", 32'h25, rd)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped", 1'b1, err)
    down(15);
    `CHK("down 20", 1'b1, flags[4])
    rst();
    `CHK("power cycle", 7'h00, flags)
    apb(1'b1, 12'h004, 32'h2);
    down(15);
    `CHK("down long", 1'b0, flags[4])
    down(5);
    `CHK("down 10", 1'b1, flags[4])
    end_sim();
  end
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
endmodule : ssf_flag_bank_tb
`default_nettype wire
